// >>> rtl/rtcc_lookup.sv
// rtc crystal temperature compensation: lookup table, indexer and rate-adjust loader
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - measurements are scheduled by hardware alone, in any power state or core halt
// - with enable set, rate fields update after every measurement; otherwise never
// - table is 128 bytes of private storage, reachable only through registers
// - index is the 11-bit signed temperature shifted right arithmetically by two
// - shifted index is clamped to the range -64 to +63
// - clamped index in two's complement addresses the 128 locations directly
// - sign-extended table byte plus 0x40000 gives a 19-bit rate value
// - upper 17 bits load the coarse field, lower 2 bits the fine field
// - temperature shows as high byte plus three bits at top of next byte
// - 7-bit table address register, reset zero, selects software access location
// - 8-bit table data register, reset zero, carries software read or write byte
// - read and write strobes stay set until the access completes, then self-clear
// - with auto-increment set, address advances by one after each strobe access
// - with auto-increment clear, address keeps its value after each access
// - read strobe copies the addressed table byte into the data register
// - coarse and fine fields reset to 0x10000 and zero, meaning no adjustment
// - a new rate value takes effect at the next one-second boundary
// - period code: 0 manual, 1 to 6 gives 2^(3+code) seconds, 7 continuous
module rtcc_lookup #(
	parameter int SECOND_CYCLES = rtcc_pkg::SECOND_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [10:0] temperature_result_i,
	input wire logic meas_done_i,
	output logic meas_start_o,
	output logic [16:0] rate_coarse_o,
	output logic [1:0] rate_fine_o,
	output logic second_tick_o
);
	import rtcc_pkg::*;

	// non-volatile store: no reset, contents survive a reset
	logic [7:0] table_mem [TABLE_DEPTH];
	logic [6:0] table_address;
	logic table_auto_increment;
	logic [7:0] table_data_byte;
	logic table_read_strobe;
	logic table_write_strobe;
	logic comp_enable;
	logic [2:0] meas_period;
	logic [10:0] temperature_result;
	logic [16:0] pend_coarse;
	logic [1:0] pend_fine;
	logic pend_valid;
	logic comp_pending;
	logic meas_busy;
	logic [24:0] sec_count;
	logic [9:0] period_count;
	rtcc_state_t state;
	rtcc_state_t next_state;
	logic [6:0] op_addr;
	logic [6:0] comp_index;
	logic [7:0] fetched;
	logic [7:0] wait_count;
	logic sec_tick;
	logic sw_done;
	logic hw_read_done;
	logic meas_due;
	logic [18:0] comp_sum;
	logic [7:0] op_data;

	// shift then limit; shift keeps sign so negative temperatures index the top half
	function automatic logic [6:0] temp_to_index(input logic [10:0] t);
		logic signed [8:0] shifted;
		logic signed [8:0] limited;
		shifted = 9'($signed(t) >>> 2);
		if (shifted < INDEX_MIN) begin
			limited = INDEX_MIN;
		end else if (shifted > INDEX_MAX) begin
			limited = INDEX_MAX;
		end else begin
			limited = shifted;
		end
		temp_to_index = limited[6:0];
	endfunction

	function automatic logic [18:0] rate_sum(input logic [7:0] entry);
		rate_sum = RATE_NOMINAL + {{11{entry[7]}}, entry};
	endfunction

	// seconds from code: 2^(3+code), codes 1..6
	function automatic logic [9:0] period_seconds(input logic [2:0] code);
		logic [3:0] exp;
		exp = PERIOD_EXP_BASE + {1'b0, code};
		period_seconds = 10'(10'h001 << exp);
	endfunction

	// nv write ends when the settle count has run out
	function automatic logic write_finished(input rtcc_state_t s, input logic [7:0] w);
		write_finished = (s == RTCC_SW_WRITE) && (w == 8'h00);
	endfunction

	wire reg_wr_addr = reg_write_i && (reg_addr_i == ADDR_TABLE_ADDR);
	wire reg_wr_data = reg_write_i && (reg_addr_i == ADDR_TABLE_DATA);
	wire reg_wr_strobe = reg_write_i && (reg_addr_i == ADDR_STROBES);
	wire reg_wr_ctrl = reg_write_i && (reg_addr_i == ADDR_COMP_CTRL);

	// one-second boundary
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sec_count <= '0;
		end else if (sec_count == 25'(SECOND_CYCLES - 1)) begin
			sec_count <= '0;
		end else begin
			sec_count <= sec_count + 25'h0000001;
		end
	end
	assign sec_tick = (sec_count == 25'(SECOND_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			second_tick_o <= 1'b0;
		end else begin
			second_tick_o <= sec_tick;
		end
	end

	// measurement scheduling never looks at processor or power state
	always_ff @(posedge clk_i) begin
		if (reset_i || meas_period == PERIOD_MANUAL) begin
			period_count <= '0;
		end else if (sec_tick) begin
			if (period_count >= period_seconds(meas_period) - 10'h001) begin
				period_count <= '0;
			end else begin
				period_count <= period_count + 10'h001;
			end
		end
	end

	always_comb begin
		meas_due = 1'b0;
		if (meas_period == PERIOD_CONTINUOUS) begin
			meas_due = !meas_busy;
		end else if (meas_period != PERIOD_MANUAL && sec_tick) begin
			meas_due = !meas_busy && (period_count >= period_seconds(meas_period) - 10'h001);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meas_start_o <= 1'b0;
			meas_busy <= 1'b0;
		end else begin
			meas_start_o <= meas_due;
			if (meas_due) begin
				meas_busy <= 1'b1;
			end else if (meas_done_i) begin
				meas_busy <= 1'b0;
			end
		end
	end

	// temperature result captured on each completed measurement
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			temperature_result <= '0;
		end else if (meas_done_i) begin
			temperature_result <= temperature_result_i;
		end
	end

	// control register: enable and period
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			comp_enable <= 1'b0;
			meas_period <= PERIOD_RESET;
		end else if (reg_wr_ctrl) begin
			comp_enable <= reg_wdata_i[BIT_COMP_ENABLE];
			meas_period <= reg_wdata_i[PERIOD_MSB:0];
		end
	end

	// lookup request; a new measurement wins over the clear of the previous one
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			comp_pending <= 1'b0;
		end else begin
			if (state == RTCC_IDLE && comp_pending) begin
				comp_pending <= 1'b0;
			end
			if (meas_done_i && comp_enable) begin
				comp_pending <= 1'b1;
			end
		end
	end

	// access engine: compensation has priority, software waits a few cycles at most
	always_comb begin
		next_state = state;
		case (state)
			RTCC_IDLE: begin
				if (comp_pending) begin
					next_state = RTCC_COMP_FETCH;
				end else if (table_read_strobe) begin
					next_state = RTCC_SW_READ;
				end else if (table_write_strobe) begin
					next_state = RTCC_SW_WRITE;
				end
			end
			RTCC_SW_READ: next_state = RTCC_IDLE;
			RTCC_SW_WRITE: begin
				if (wait_count == 8'h00) begin
					next_state = RTCC_IDLE;
				end
			end
			RTCC_COMP_FETCH: next_state = RTCC_COMP_SUM;
			RTCC_COMP_SUM: next_state = RTCC_IDLE;
			default: next_state = RTCC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= RTCC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// address and index latched at start so software writes mid-access are harmless
	// the data byte too, so a rewrite of the data register cannot alter a write in flight
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			op_addr <= '0;
			op_data <= '0;
			comp_index <= '0;
			wait_count <= '0;
		end else if (state == RTCC_IDLE) begin
			op_addr <= table_address;
			op_data <= table_data_byte;
			comp_index <= temp_to_index(temperature_result);
			wait_count <= NV_WRITE_CNT - 8'h01;
		end else if (wait_count != 8'h00) begin
			wait_count <= wait_count - 8'h01;
		end
	end

	assign sw_done = (state == RTCC_SW_READ)
		|| write_finished(state, wait_count);
	assign hw_read_done = (state == RTCC_SW_READ);

	// one adder feeds both fields so they can never come from different entries
	assign comp_sum = rate_sum(fetched);

	// table store, written only by the engine
	always_ff @(posedge clk_i) begin
		if (write_finished(state, wait_count)) begin
			table_mem[op_addr] <= op_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fetched <= '0;
		end else if (state == RTCC_COMP_FETCH) begin
			fetched <= table_mem[comp_index];
		end
	end

	// strobes: software sets, hardware clears on completion; a set wins
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			table_read_strobe <= 1'b0;
			table_write_strobe <= 1'b0;
		end else begin
			if (state == RTCC_SW_READ) begin
				table_read_strobe <= 1'b0;
			end
			if (write_finished(state, wait_count)) begin
				table_write_strobe <= 1'b0;
			end
			if (reg_wr_strobe && reg_wdata_i[BIT_READ_STROBE]) begin
				table_read_strobe <= 1'b1;
			end
			if (reg_wr_strobe && reg_wdata_i[BIT_WRITE_STROBE]) begin
				table_write_strobe <= 1'b1;
			end
		end
	end

	// address register; a software write in the completing cycle wins
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			table_address <= TABLE_ADDR_RESET;
			table_auto_increment <= 1'b0;
		end else if (reg_wr_addr) begin
			table_address <= reg_wdata_i[6:0];
			table_auto_increment <= reg_wdata_i[BIT_AUTO_INC];
		end else if (sw_done && table_auto_increment) begin
			table_address <= table_address + 7'h01;
		end
		// with auto-increment clear the address simply holds
	end

	// data register; the table byte from a read wins over a software write
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			table_data_byte <= TABLE_DATA_RESET;
		end else if (hw_read_done) begin
			table_data_byte <= table_mem[op_addr];
		end else if (reg_wr_data) begin
			table_data_byte <= reg_wdata_i;
		end
	end

	// computed value waits for the next second boundary
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pend_coarse <= RATE_COARSE_RESET;
			pend_fine <= RATE_FINE_RESET;
			pend_valid <= 1'b0;
		end else begin
			if (sec_tick) begin
				pend_valid <= 1'b0;
			end
			// last lookup before a boundary wins; earlier ones in that second are dropped
			if (state == RTCC_COMP_SUM) begin
				pend_coarse <= comp_sum[18:2];
				pend_fine <= comp_sum[1:0];
				pend_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rate_coarse_o <= RATE_COARSE_RESET;
			rate_fine_o <= RATE_FINE_RESET;
		end else if (sec_tick && pend_valid) begin
			rate_coarse_o <= pend_coarse;
			rate_fine_o <= pend_fine;
		end
	end

	// register read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				ADDR_TEMP_HIGH: reg_rdata_o <= temperature_result[10:3];
				ADDR_TEMP_LOW: reg_rdata_o <= {temperature_result[2:0], 5'h00};
				ADDR_TABLE_ADDR: reg_rdata_o <= {table_auto_increment, table_address};
				ADDR_TABLE_DATA: reg_rdata_o <= table_data_byte;
				ADDR_STROBES: reg_rdata_o <= {6'h00, table_read_strobe, table_write_strobe};
				ADDR_RATE_P_HIGH: reg_rdata_o <= {5'h00, rate_coarse_o[16:14]};
				ADDR_RATE_P_MID: reg_rdata_o <= rate_coarse_o[13:6];
				ADDR_RATE_P_LOW: reg_rdata_o <= {rate_coarse_o[5:0], rate_fine_o};
				ADDR_COMP_CTRL: reg_rdata_o <= {2'h0, comp_enable, 2'h0, meas_period};
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule

`default_nettype wire

// >>> rtl/rtcc_pkg.sv
// constants for the rtc temperature compensation lookup block
package rtcc_pkg;
	// clock
	localparam int CLK_HZ = 20000000;
	localparam int SECOND_TIME_S = 1;
	localparam int SECOND_CYCLES = CLK_HZ * SECOND_TIME_S;
	localparam int NV_WRITE_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] NV_WRITE_CNT = NV_WRITE_CYCLES[7:0];

	// register byte addresses
	localparam logic [15:0] ADDR_TEMP_HIGH = 16'h2881;
	localparam logic [15:0] ADDR_TEMP_LOW = 16'h2882;
	localparam logic [15:0] ADDR_TABLE_ADDR = 16'h2887;
	localparam logic [15:0] ADDR_TABLE_DATA = 16'h2888;
	localparam logic [15:0] ADDR_STROBES = 16'h2889;
	localparam logic [15:0] ADDR_RATE_P_HIGH = 16'h289b;
	localparam logic [15:0] ADDR_RATE_P_MID = 16'h289c;
	localparam logic [15:0] ADDR_RATE_P_LOW = 16'h289d;
	localparam logic [15:0] ADDR_COMP_CTRL = 16'h28a0;

	// field positions
	localparam int BIT_AUTO_INC = 7;
	localparam int BIT_READ_STROBE = 1;
	localparam int BIT_WRITE_STROBE = 0;
	localparam int BIT_COMP_ENABLE = 5;
	localparam int PERIOD_MSB = 2;

	// reset values
	localparam logic [6:0] TABLE_ADDR_RESET = 7'h00;
	localparam logic [7:0] TABLE_DATA_RESET = 8'h00;
	localparam logic [2:0] PERIOD_RESET = 3'h0;
	localparam logic [16:0] RATE_COARSE_RESET = 17'h10000;
	localparam logic [1:0] RATE_FINE_RESET = 2'h0;

	// compensation arithmetic
	localparam int TABLE_DEPTH = 128;
	localparam logic [18:0] RATE_NOMINAL = 19'h40000;
	localparam logic signed [8:0] INDEX_MIN = -9'sd64;
	localparam logic signed [8:0] INDEX_MAX = 9'sd63;

	// measurement period codes
	localparam logic [2:0] PERIOD_MANUAL = 3'h0;
	localparam logic [2:0] PERIOD_CONTINUOUS = 3'h7;
	localparam logic [3:0] PERIOD_EXP_BASE = 4'h3;

	typedef enum logic [2:0] {
		RTCC_IDLE = 3'b000,
		RTCC_SW_READ = 3'b001,
		RTCC_SW_WRITE = 3'b010,
		RTCC_COMP_FETCH = 3'b011,
		RTCC_COMP_SUM = 3'b100
	} rtcc_state_t;
endpackage

// >>> testbench/rtcc_lookup_monitor.sv
// assertion checker for the rtc temperature compensation lookup block
`timescale 1ns/1ps
`default_nettype none
module rtcc_lookup_monitor
	import rtcc_pkg::*;
#(
	parameter int SECOND_CYCLES = rtcc_pkg::SECOND_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [10:0] temperature_result_i,
	input wire logic meas_done_i,
	input wire logic meas_start_o,
	input wire logic [16:0] rate_coarse_o,
	input wire logic [1:0] rate_fine_o,
	input wire logic second_tick_o
);
	logic [10:0] temp;
	logic [2:0] period;
	logic ever_en;
	logic seen_tick;
	logic [31:0] gap;
	wire ctrl_wr = reg_write_i && reg_addr_i == ADDR_COMP_CTRL;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// shadows of the sampled temperature and the control byte
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			temp <= 11'h000;
			period <= 3'h0;
			ever_en <= 1'b0;
		end else begin
			if (meas_done_i) temp <= temperature_result_i;
			if (ctrl_wr) period <= reg_wdata_i[2:0];
			if (ctrl_wr && reg_wdata_i[BIT_COMP_ENABLE]) ever_en <= 1'b1;
		end
	end
	// first tick after reset has no reference, so spacing is checked from the second on
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			seen_tick <= 1'b0;
			gap <= 32'h0;
		end else begin
			seen_tick <= seen_tick | second_tick_o;
			gap <= second_tick_o ? 32'h0 : gap + 32'h1;
		end
	end
	rate_on_tick_a: assert property ($changed({rate_coarse_o, rate_fine_o}) |-> second_tick_o)
		else $error("rate changed off a second boundary");
	tick_spacing_a: assert property (second_tick_o && seen_tick |-> gap == SECOND_CYCLES - 1)
		else $error("second tick spacing wrong");
	rate_range_a: assert property (
		{rate_coarse_o, rate_fine_o} inside {[19'h3ff80:19'h4007f]})
		else $error("rate outside nominal plus signed byte");
	rate_default_a: assert property (
		!ever_en |-> rate_coarse_o == RATE_COARSE_RESET && rate_fine_o == RATE_FINE_RESET)
		else $error("rate moved without compensation enabled");
	read_idle_a: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read cycle");
	temp_high_a: assert property (
		reg_read_i && reg_addr_i == ADDR_TEMP_HIGH && !meas_done_i |=> reg_rdata_o == temp[10:3])
		else $error("temperature high byte wrong");
	temp_low_a: assert property (
		reg_read_i && reg_addr_i == ADDR_TEMP_LOW && !meas_done_i
		|=> reg_rdata_o == {temp[2:0], 5'h00})
		else $error("temperature low bits wrong");
	start_pulse_a: assert property (meas_start_o |=> !meas_start_o)
		else $error("measurement start longer than one cycle");
	manual_quiet_a: assert property (
		period == PERIOD_MANUAL && $past(period) == PERIOD_MANUAL |-> !meas_start_o)
		else $error("measurement started in manual mode");
	cont_restart_a: assert property (
		period == PERIOD_CONTINUOUS && meas_done_i |-> ##[1:3] meas_start_o)
		else $error("continuous mode did not restart");
endmodule

bind rtcc_lookup rtcc_lookup_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) monitor (
	.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
	.temperature_result_i(temperature_result_i), .meas_done_i(meas_done_i),
	.meas_start_o(meas_start_o), .rate_coarse_o(rate_coarse_o), .rate_fine_o(rate_fine_o),
	.second_tick_o(second_tick_o));
`default_nettype wire

// >>> testbench/rtcc_lookup_test.sv
// self-checking testbench for the rtc temperature compensation lookup block
`timescale 1ns/1ps
`default_nettype none
module rtcc_lookup_test;
	import rtcc_pkg::*;
	// short second keeps the longest measurement period inside the run
	localparam int SC = 20;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] reg_addr_i = 16'h0;
	logic [7:0] reg_wdata_i = 8'h0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [10:0] temperature_result_i = 11'h0;
	logic meas_done_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic meas_start_o;
	logic [16:0] rate_coarse_o;
	logic [1:0] rate_fine_o;
	logic second_tick_o;
	int num_errors = 0;
	int checked = 0;
	int seed = 12;
	int n;
	logic [7:0] mem [128];
	logic [8:0] exp_q [$];
	logic [8:0] e;
	logic rd_seen = 1'b0;
	logic [7:0] last_rd = 8'h0;
	logic [18:0] rate_m = 19'h40000;
	logic [6:0] a;
	logic [23:0] rst_tab [10] = '{24'h288100, 24'h288200, 24'h288700, 24'h288800, 24'h288900,
		24'h28a000, 24'h289b04, 24'h289c00, 24'h289d00, 24'h288500};
	logic [10:0] temps [10] = '{11'h400, 11'h6ff, 11'h700, 11'h7f7, 11'h7ff, 11'h000, 11'h005,
		11'h0ff, 11'h100, 11'h3ff};
	rtcc_lookup #(.SECOND_CYCLES(SC)) uut (.clk_i(clk_i), .reset_i(reset_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
		.temperature_result_i(temperature_result_i), .meas_done_i(meas_done_i),
		.meas_start_o(meas_start_o), .rate_coarse_o(rate_coarse_o), .rate_fine_o(rate_fine_o),
		.second_tick_o(second_tick_o));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error: %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read data belongs to the cycle after the strobe only
	always @(posedge clk_i) rd_seen <= reg_read_i;
	always @(negedge clk_i) begin
		if (rd_seen) begin
			e = exp_q.pop_front();
			last_rd = reg_rdata_o;
			if (e[8]) check("read data", {11'h0, e[7:0]}, {11'h0, reg_rdata_o});
		end
	end
	// one idle cycle after each strobe so a strobe is never driven twice in one step
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [15:0] ad, input logic chk, input logic [7:0] d);
		exp_q.push_back({chk, d});
		reg_addr_i <= ad;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic poll();
		int k;
		k = 0;
		do begin
			rd(ADDR_STROBES, 1'b0, 8'h0);
			k++;
		end while (last_rd !== 8'h00 && k < 40);
		check("strobes", 19'h0, {11'h0, last_rd});
	endtask
	task automatic pulse(input logic [10:0] t);
		temperature_result_i <= t;
		meas_done_i <= 1'b1;
		@(posedge clk_i);
		meas_done_i <= 1'b0;
	endtask
	task automatic wait_for(input bit start, input int bound);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while ((start ? meas_start_o : second_tick_o) !== 1'b1 && n < bound);
		check("pulse", 19'h1, {18'h0, start ? meas_start_o : second_tick_o});
		@(posedge clk_i);
	endtask
	function automatic logic [6:0] idx_of(input logic signed [10:0] t);
		logic signed [10:0] s;
		s = t >>> 2;
		if (s < -11'sd64) s = -11'sd64;
		if (s > 11'sd63) s = 11'sd63;
		return s[6:0];
	endfunction
	task automatic comp(input logic [10:0] t, input bit en, input bit clash);
		logic [7:0] b;
		b = mem[idx_of(t)];
		wait_for(1'b0, SC + 2);
		fork
			if (clash) wr(ADDR_STROBES, 8'h01);
			pulse(t);
		join
		if (en) rate_m = 19'h40000 + {{11{b[7]}}, b};
		wait_for(1'b0, SC + 2);
		wait_for(1'b0, SC + 2);
		check("rate", rate_m, {rate_coarse_o, rate_fine_o});
		rd(ADDR_RATE_P_HIGH, 1'b1, {5'h0, rate_m[18:16]});
		rd(ADDR_RATE_P_MID, 1'b1, rate_m[15:8]);
		rd(ADDR_RATE_P_LOW, 1'b1, rate_m[7:0]);
		rd(ADDR_TEMP_HIGH, 1'b1, t[10:3]);
		rd(ADDR_TEMP_LOW, 1'b1, {t[2:0], 5'h0});
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		wr(ADDR_TEMP_HIGH, 8'hff);
		wr(ADDR_RATE_P_MID, 8'hff);
		foreach (rst_tab[i]) rd(rst_tab[i][23:8], 1'b1, rst_tab[i][7:0]);
		// table filled as plain storage while compensation stays off
		wr(ADDR_TABLE_ADDR, 8'h80);
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'($random(seed));
			wr(ADDR_TABLE_DATA, mem[i]);
			wr(ADDR_STROBES, 8'h01);
			poll();
		end
		rd(ADDR_TABLE_ADDR, 1'b1, 8'h80);
		for (int k = 0; k < 4; k++) begin
			a = 7'($random(seed));
			wr(ADDR_TABLE_ADDR, {k[0], a});
			wr(ADDR_STROBES, 8'h02);
			poll();
			rd(ADDR_TABLE_DATA, 1'b1, mem[a]);
			rd(ADDR_TABLE_ADDR, 1'b1, {k[0], a + 7'(k[0])});
		end
		wr(ADDR_COMP_CTRL, 8'h20);
		foreach (temps[i]) comp(temps[i], 1'b1, 1'b0);
		comp(11'($random(seed)), 1'b1, 1'b0);
		wr(ADDR_TABLE_ADDR, 8'h10);
		wr(ADDR_TABLE_DATA, 8'h5a);
		comp(11'h0ff, 1'b1, 1'b1);
		mem[16] = 8'h5a;
		wr(ADDR_TABLE_DATA, 8'h00);
		wr(ADDR_STROBES, 8'h02);
		poll();
		rd(ADDR_TABLE_DATA, 1'b1, 8'h5a);
		wr(ADDR_COMP_CTRL, 8'h00);
		comp(11'h7c0, 1'b0, 1'b0);
		// continuous mode last: its restart leaves a measurement outstanding
		for (int c = 1; c < 8; c++) begin
			wr(ADDR_COMP_CTRL, 8'(c));
			wait_for(1'b1, ((1 << (3 + c)) + 1) * SC + 4);
			pulse(11'h0);
			wait_for(1'b1, ((1 << (3 + c)) + 1) * SC + 4);
			check("gap", 19'h1, 19'(c == 7 ? n <= 3 : n == (1 << (3 + c)) * SC - 1));
			// finish the measurement just started, or the next period can never schedule one
			pulse(11'h0);
		end
		wrap_up();
	end
	initial begin
		#(90000 * 50);
		num_errors++;
		$display("Error: run end expected done seen timeout");
		wrap_up();
	end
endmodule
`default_nettype wire
